// ### div_link_if.sv
// Link between the register side and the pulse divider.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface div_link_if;
    logic                              enable;   // Latch enabled, divider runs
    logic [srl_pkg::SEL_W-1:0]         select;   // Divider select code
    logic                              tick;     // One-cycle divided pulse
    modport ctl (output enable, output select, input tick);
    modport div (input enable, input select, output tick);
endinterface

// ### pulse_divider.sv
// Programmable divider: one-cycle pulse every 4 to 512 clocks.
// Assumes the enable and select arrive synchronous to clock.
`timescale 1ns/10ps
module pulse_divider
    import srl_pkg::*;
(
    input  wire logic clock,         // System clock
    input  wire logic rst_b,         // Synchronous reset, active low
    div_link_if.div   link           // Enable, select, tick
);
    logic [DIV_CNT_W-1:0] cnt_r;
    logic [DIV_CNT_W-1:0] cnt_nxt;
    logic [DIV_CNT_W-1:0] last;
    logic                 tick_r;
    logic                 tick_nxt;

    always_comb begin
        // One spare bit keeps the top code's shift from wrapping before the subtraction
        last = DIV_CNT_W'(({1'b0, DIV_BASE} << link.select) - 1'b1);
        tick_nxt = 1'b0;
        // A shrinking select may leave the count past the end; wrap on >= for that
        if (!link.enable) begin
            cnt_nxt = '0;
        end else if (cnt_r >= last) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + DIV_CNT_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign link.tick = tick_r;

    AST_DIV_RESTART: assert property (@(posedge clock) disable iff (!rst_b)
        !link.enable |=> cnt_r == '0 && !tick_r)
        else $error("divider did not restart while disabled");
    AST_DIV_PERIOD4: assert property (@(posedge clock) disable iff (!rst_b)
        (tick_r && link.enable && link.select == 3'h0)
        ##1 (link.enable && link.select == 3'h0)[*3] |=> tick_r)
        else $error("divide-by-4 period wrong");
    AST_DIV_GAP: assert property (@(posedge clock) disable iff (!rst_b)
        tick_r |=> !tick_r)
        else $error("divider pulse wider than one cycle");
    COV_DIV_512: cover property (@(posedge clock) disable iff (!rst_b)
        tick_r && link.select == 3'h7);
endmodule

// ### sr_latch_control.sv
// Set/reset latch with software pulses, pin enables and a pulse divider.
// Assumes a single AHB-Lite master; this slave's hreadyout is the bus hready.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
module sr_latch_control
    import srl_pkg::*;
(
    input  wire logic        clock,                     // System clock, 10 MHz
    input  wire logic        rst_b,                     // Synchronous reset, active low
    input  wire logic        hsel,                      // Slave select
    input  wire logic [31:0] haddr,                     // Byte address
    input  wire logic [1:0]  htrans,                    // Transfer type
    input  wire logic        hwrite,                    // Write when high
    input  wire logic [2:0]  hsize,                     // Transfer size, word only
    input  wire logic [31:0] hwdata,                    // Write data
    input  wire logic        hready,                    // Bus ready
    output logic      [31:0] hrdata,                    // Read data
    output logic             hreadyout,                 // Ready except during reset
    output logic             hresp,                     // Always OKAY
    output logic             q_output_pin,              // Latch Q value
    output logic             q_output_pin_oe_b,         // Q pin drive, low drives
    output logic             inverted_output_pin,       // Latch inverted value
    output logic             inverted_output_pin_oe_b,  // Inverted pin drive, low drives
    output logic             divider_tick               // Divided one-cycle pulse
);
    div_link_if link ();

    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic        wr_pend_r;
    logic        wr_pend_nxt;
    logic        set_pulse_r;
    logic        set_pulse_nxt;
    logic        rst_pulse_r;
    logic        rst_pulse_nxt;
    logic [31:0] hrdata_nxt;
    logic        q_r;
    logic        q_nxt;
    logic        q_pin_nxt;
    logic        q_oe_b_nxt;
    logic        nq_pin_nxt;
    logic        nq_oe_b_nxt;
    logic        addr_take;
    logic        hit;
    logic        latch_enable_bit;

    // Zero wait states: hreadyout stays high, so every NONSEQ transfer is taken at its address edge
    assign addr_take        = hsel && hready && htrans == HTRANS_NONSEQ;
    assign hit              = haddr == ADDR_LATCH_CONTROL;
    assign latch_enable_bit = ctrl_r[BIT_ENABLE];

    always_comb begin
        ctrl_nxt      = ctrl_r;
        set_pulse_nxt = 1'b0;
        rst_pulse_nxt = 1'b0;
        wr_pend_nxt   = addr_take && hwrite && hit;
        hrdata_nxt    = hrdata;
        if (wr_pend_r) begin
            ctrl_nxt      = hwdata[7:0] & READ_PULSE_MASK;
            set_pulse_nxt = hwdata[BIT_SET_PULSE];
            rst_pulse_nxt = hwdata[BIT_RST_PULSE];
        end
        if (addr_take && !hwrite) begin
            // A read right behind a write sees the new value, as a pipelined master expects
            hrdata_nxt = hit ? {24'h00_0000, ctrl_nxt & READ_PULSE_MASK} : RDATA_ZERO;
        end
    end

    // Disabling drops Q, so a later enable always starts from a known state
    always_comb begin
        q_nxt = q_r;
        if (!latch_enable_bit) begin
            q_nxt = 1'b0;
        end else if (rst_pulse_r) begin
            q_nxt = 1'b0;
        end else if (set_pulse_r) begin
            q_nxt = 1'b1;
        end
        q_pin_nxt   = latch_enable_bit && ctrl_r[BIT_Q_OE] && q_r;
        q_oe_b_nxt  = !(latch_enable_bit && ctrl_r[BIT_Q_OE]);
        nq_pin_nxt  = latch_enable_bit && ctrl_r[BIT_NQ_OE] && !q_r;
        nq_oe_b_nxt = !(latch_enable_bit && ctrl_r[BIT_NQ_OE]);
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_r                   <= LATCH_CONTROL_RST;
            wr_pend_r                <= 1'b0;
            set_pulse_r              <= 1'b0;
            rst_pulse_r              <= 1'b0;
            hrdata                   <= RDATA_ZERO;
            hreadyout                <= 1'b0;
            hresp                    <= 1'b0;
        end else begin
            ctrl_r                   <= ctrl_nxt;
            wr_pend_r                <= wr_pend_nxt;
            set_pulse_r              <= set_pulse_nxt;
            rst_pulse_r              <= rst_pulse_nxt;
            hrdata                   <= hrdata_nxt;
            hreadyout                <= 1'b1;
            hresp                    <= 1'b0;
        end
    end

    // Pins trail q_r by one register so every pin comes straight from a flip-flop
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            q_r                      <= 1'b0;
            q_output_pin             <= 1'b0;
            q_output_pin_oe_b        <= 1'b1;
            inverted_output_pin      <= 1'b0;
            inverted_output_pin_oe_b <= 1'b1;
            divider_tick             <= 1'b0;
        end else begin
            q_r                      <= q_nxt;
            q_output_pin             <= q_pin_nxt;
            q_output_pin_oe_b        <= q_oe_b_nxt;
            inverted_output_pin      <= nq_pin_nxt;
            inverted_output_pin_oe_b <= nq_oe_b_nxt;
            divider_tick             <= link.tick;
        end
    end

    assign link.enable = latch_enable_bit;
    assign link.select = ctrl_r[SEL_HI:SEL_LO];

    pulse_divider u_div (
        .clock (clock),
        .rst_b (rst_b),
        .link  (link.div)
    );

    AST_CTRL_RESET: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> ctrl_r == LATCH_CONTROL_RST && !q_r)
        else $error("control not cleared by reset");
    AST_SET_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
        wr_pend_r |=> set_pulse_r == $past(hwdata[BIT_SET_PULSE]))
        else $error("set pulse does not follow write");
    AST_RST_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
        wr_pend_r |=> rst_pulse_r == $past(hwdata[BIT_RST_PULSE]))
        else $error("reset pulse does not follow write");
    AST_READ_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
        hrdata[BIT_SET_PULSE] == 1'b0 && hrdata[BIT_RST_PULSE] == 1'b0)
        else $error("pulse bits read back non-zero");
    AST_LATCH_PRIO: assert property (@(posedge clock) disable iff (!rst_b)
        latch_enable_bit && rst_pulse_r |=> !q_r)
        else $error("reset pulse did not win");
    AST_LATCH_SET: assert property (@(posedge clock) disable iff (!rst_b)
        latch_enable_bit && set_pulse_r && !rst_pulse_r |=> q_r)
        else $error("set pulse did not set latch");
    AST_Q_PIN: assert property (@(posedge clock) disable iff (!rst_b)
        latch_enable_bit && ctrl_r[BIT_Q_OE] |=> !q_output_pin_oe_b && q_output_pin == $past(q_r))
        else $error("Q pin not driven with latch value");
    AST_NQ_PIN: assert property (@(posedge clock) disable iff (!rst_b)
        latch_enable_bit && ctrl_r[BIT_NQ_OE]
        |=> !inverted_output_pin_oe_b && inverted_output_pin == !$past(q_r))
        else $error("inverted pin not driven with complement");
    AST_DISABLED: assert property (@(posedge clock) disable iff (!rst_b)
        !latch_enable_bit |=> q_output_pin_oe_b && inverted_output_pin_oe_b && !q_r
        && !q_output_pin && !inverted_output_pin)
        else $error("pins driven while latch disabled");
    AST_Q_OFF: assert property (@(posedge clock) disable iff (!rst_b)
        latch_enable_bit && !ctrl_r[BIT_Q_OE] |=> q_output_pin_oe_b && !q_output_pin)
        else $error("Q pin driven with its enable clear");
    AST_NQ_OFF: assert property (@(posedge clock) disable iff (!rst_b)
        latch_enable_bit && !ctrl_r[BIT_NQ_OE] |=> inverted_output_pin_oe_b && !inverted_output_pin)
        else $error("inverted pin driven with its enable clear");
    AST_PIN_IDLE_LOW: assert property (@(posedge clock) disable iff (!rst_b)
        !(q_output_pin_oe_b && q_output_pin) && !(inverted_output_pin_oe_b && inverted_output_pin))
        else $error("released pin shows a high value");
    AST_COMPLEMENT: assert property (@(posedge clock) disable iff (!rst_b)
        !q_output_pin_oe_b && !inverted_output_pin_oe_b |-> q_output_pin != inverted_output_pin)
        else $error("driven pins are not complementary");

    // Latch state and pulse shape
    AST_Q_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
        latch_enable_bit && !set_pulse_r && !rst_pulse_r |=> q_r == $past(q_r))
        else $error("latch changed without a pulse");
    AST_SET_ONCE: assert property (@(posedge clock) disable iff (!rst_b)
        set_pulse_r && !wr_pend_r |=> !set_pulse_r)
        else $error("set pulse longer than one cycle");
    AST_RST_ONCE: assert property (@(posedge clock) disable iff (!rst_b)
        rst_pulse_r && !wr_pend_r |=> !rst_pulse_r)
        else $error("reset pulse longer than one cycle");

    // Register bus and reset
    AST_BUS_READY: assert property (@(posedge clock) disable iff (!rst_b)
        $past(rst_b) |-> hreadyout && !hresp)
        else $error("bus not ready or error response");
    AST_WRITE_STORE: assert property (@(posedge clock) disable iff (!rst_b)
        wr_pend_r |=> ctrl_r == ($past(hwdata[7:0]) & READ_PULSE_MASK))
        else $error("write did not land in control");
    AST_RESET_PINS: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> q_output_pin_oe_b && inverted_output_pin_oe_b && !divider_tick)
        else $error("outputs not in reset state");

    // Divided pulse as seen on the pin
    AST_TICK_OFF: assert property (@(posedge clock) disable iff (!rst_b)
        !latch_enable_bit ##1 !latch_enable_bit |=> !divider_tick)
        else $error("divided pulse while disabled");
    AST_TICK_ONE: assert property (@(posedge clock) disable iff (!rst_b)
        divider_tick |=> !divider_tick)
        else $error("divided pulse wider than one cycle");

    COV_SET:   cover property (@(posedge clock) disable iff (!rst_b) set_pulse_r ##1 q_r);
    COV_BOTH:  cover property (@(posedge clock) disable iff (!rst_b) set_pulse_r && rst_pulse_r);
    COV_RESET: cover property (@(posedge clock) disable iff (!rst_b) q_r ##1 rst_pulse_r ##1 !q_r);
    COV_READ:  cover property (@(posedge clock) disable iff (!rst_b) addr_take && !hwrite && hit);
endmodule

// ### srl_pkg.sv
// Shared constants for the set/reset latch control block.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
package srl_pkg;
    localparam logic [31:0] ADDR_LATCH_CONTROL = 32'h0000_0000;
    localparam logic [7:0]  LATCH_CONTROL_RST  = 8'h00;
    localparam int          BIT_ENABLE         = 7;
    localparam int          SEL_HI             = 6;
    localparam int          SEL_LO             = 4;
    localparam int          BIT_Q_OE           = 3;
    localparam int          BIT_NQ_OE          = 2;
    localparam int          BIT_SET_PULSE      = 1;
    localparam int          BIT_RST_PULSE      = 0;
    localparam int          SEL_W              = 3;
    localparam int          DIV_CNT_W          = 9;
    localparam logic [DIV_CNT_W-1:0] DIV_BASE  = 9'h004;
    localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
    localparam logic [31:0] RDATA_ZERO         = 32'h0000_0000;
    localparam logic [7:0]  READ_PULSE_MASK    = 8'hfc;
endpackage

// ### testbench.sv
// Self-checking bench for the set/reset latch control block.
// Assumes srl_pkg and the design files are compiled first; one AHB-Lite master.
`timescale 1ns/10ps
module testbench;
    import srl_pkg::*;
    logic        clock;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        q_pin;
    logic        q_oe_b;
    logic        nq_pin;
    logic        nq_oe_b;
    logic        tick;
    logic [31:0] rd;
    int          num_errors;
    int          comparisons;
    int          n;

    sr_latch_control sr_latch_control_inst (
        .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .q_output_pin(q_pin), .q_output_pin_oe_b(q_oe_b),
        .inverted_output_pin(nq_pin), .inverted_output_pin_oe_b(nq_oe_b),
        .divider_tick(tick)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Single word transfer; waits on hready in both phases, no assumed latency
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= addr;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    // Expected order {q_oe_b, q, nq_oe_b, nq}; pins trail the pulse by a few edges
    task automatic pins(input logic [3:0] exp);
        repeat (4) @(posedge clock);
        #1;
        check("pins", {28'h0, q_oe_b, q_pin, nq_oe_b, nq_pin}, {28'h0, exp});
    endtask

    task automatic wait_tick(input int lim);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (tick !== 1'b1 && n < lim);
    endtask

    task automatic results;
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Whole run is a few thousand cycles; this limit only cuts a hang
    initial begin
        #2000000;
        num_errors++;
        results();
    end

    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        bus(1'b0, ADDR_LATCH_CONTROL, 32'h0);
        check("reset value", rd, {24'h0, LATCH_CONTROL_RST});
        pins(4'b1010);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h82);
        bus(1'b0, ADDR_LATCH_CONTROL, 32'h0);
        check("set bit reads zero", rd, 32'h80);
        pins(4'b1010);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h8c);
        pins(4'b0100);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h88);
        pins(4'b0110);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h85);
        pins(4'b1001);
        bus(1'b0, ADDR_LATCH_CONTROL, 32'h0);
        check("reset bit reads zero", rd, 32'h84);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h8e);
        pins(4'b0100);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h8f);
        pins(4'b0001);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h0f);
        pins(4'b1010);
        bus(1'b0, ADDR_LATCH_CONTROL, 32'h0);
        check("disabled readback", rd, 32'h0c);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h0e);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h8c);
        pins(4'b0001);
        // Unmapped place: write ignored, read returns zero
        bus(1'b1, 32'h4, 32'hff);
        bus(1'b0, 32'h4, 32'h0);
        check("unmapped read", rd, 32'h0);
        bus(1'b0, ADDR_LATCH_CONTROL, 32'h0);
        check("unmapped write", rd, 32'h8c);
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, ADDR_LATCH_CONTROL, 32'h0);
            bus(1'b1, ADDR_LATCH_CONTROL, 32'h80 | (s << 4));
            wait_tick(600);
            // Count restarts at the enabling edge; the pin adds one register stage
            check("first tick", n, (int'(DIV_BASE) << s) + 1);
            wait_tick(600);
            check("tick period", n, int'(DIV_BASE) << s);
        end
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h0);
        wait_tick(40);
        check("no tick while off", n, 40);
        bus(1'b1, ADDR_LATCH_CONTROL, 32'h8e);
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        bus(1'b0, ADDR_LATCH_CONTROL, 32'h0);
        check("value after reset", rd, 32'h0);
        pins(4'b1010);
        results();
    end
endmodule
